// File: verilog/bcsc_regs.svh
`ifndef BCSC_REGS_SVH
`define BCSC_REGS_SVH

// Register byte offsets
`define BCSC_CTRL_OFS        8'h00
`define BCSC_STATUS_OFS      8'h04
`define BCSC_PEAK_OFS        8'h08
`define BCSC_TIMER_OFS       8'h0c

// Control register fields and reset value
`define BCSC_CTRL_ALLOW_BIT  0
`define BCSC_CTRL_RESTART_BIT 1
`define BCSC_CTRL_RESET      1'h1

// Status register field positions
`define BCSC_ST_STATE_LSB    0
`define BCSC_ST_SUSP_BIT     3
`define BCSC_ST_FULL_BIT     4
`define BCSC_ST_IND_BIT      5
`define BCSC_ST_LOCK_BIT     6
`define BCSC_ST_OVWAIT_BIT   7
`define BCSC_ST_DVEN_BIT     8
`define BCSC_ST_DROP_LSB     9
`define BCSC_ST_CELLS_LSB    11

// Drop magnitudes in converter steps of 1.5 mV, rounded up (16 mV, 8 mV)
`define BCSC_DROP_NICD       12'h00b
`define BCSC_DROP_NIMH       12'h006
`define BCSC_DROP_LAST       2'h3

// Timing in oscillator ticks
`define BCSC_EVT_LAST        5'h0f
`define BCSC_SAMPLE_TICKS    16'h04b0
`define BCSC_HOLDOFF_TICKS   20'h0_6720
`define BCSC_CHARGE_TIME_LIMIT_TICKS      20'h4_d580

`endif

// File: verilog/bcsc_pkg.sv
package bcsc_pkg;

  typedef enum logic [2:0] {
    ST_SLEEP     = 3'h0,
    ST_SHUTDOWN  = 3'h1,
    ST_QUALIFY   = 3'h3,
    ST_PRECHARGE = 3'h2,
    ST_FAST      = 3'h6,
    ST_DONE      = 3'h7
  } bcsc_state_e;

  // Comparator and pin levels from the analog side
  typedef struct packed {
    logic above_removal;
    logic above_overvoltage;
    logic below_ov_release;
    logic above_fast_entry;
    logic above_holdoff_bypass;
    logic thermistor_disabled;
    logic temp_ok_45;
    logic temp_ok_55;
    logic supply_lockout;
    logic die_overtemp;
    logic stop_request_n;
    logic chemistry_select;
    logic cell_count_select_lo;
    logic cell_count_select_hi;
    logic osc_tick;
  } bcsc_pins_s;

  typedef logic [11:0] bcsc_sample_t;

endpackage

// File: verilog/bcsc_top.sv
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ns
`include "bcsc_regs.svh"

// What this block does
// - Battery present below removal threshold
// - Persisting overvoltage stops charging with flag
// - Overvoltage restart needs low voltage plus event
// - Enabled thermistor must read 5 to 45, in fast charge up to 55
// - Monitor always; supply lockout enters sleep
// - Die overtemperature shuts down, restart by event
// - Start in precharge; indicator low while charging
// - Below fast entry: precharge at fifth current
// - Precharge temperature fault suspends, pauses timer
// - Above fast entry: fast charge, full current
// - Fast suspend pauses; resume resets drop detect
// - Imminent drop termination at suspend terminates
// - Hold-off delays drop termination after fast start
// - High voltage before precharge skips hold-off
// - Sample cell voltage each interval, keep peak
// - Four consecutive drops below peak terminate
// - Drop 16 mV nickel-cadmium, 8 mV metal-hydride
// - Timer expiry or overvoltage ends, restart by event
// - Qualify listed events after filter persistence
// - Decode cell count selects into one to four
module bcsc_top
  import bcsc_pkg::*;
#(
  parameter logic [19:0] CHARGE_TIME_LIMIT_TICKS    = `BCSC_CHARGE_TIME_LIMIT_TICKS,
  parameter logic [19:0] HOLDOFF_TICKS = `BCSC_HOLDOFF_TICKS,
  parameter logic [15:0] SAMPLE_TICKS  = `BCSC_SAMPLE_TICKS
) (
  // Clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         arst_n_i,
  // Analog comparators and pins
  input  wire bcsc_pins_s   pins_i,
  // Cell voltage converter
  input  wire bcsc_sample_t adc_data_i,
  input  wire logic         adc_valid_i,
  output logic              adc_start_o,
  // Charge path control
  output logic              charge_enable_o,
  output logic              current_full_o,
  output logic [2:0]        cell_count_o,
  output logic              charging_indicator_n_o,
  output logic              charging_indicator_oe_o,
  // APB slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr
);

  localparam int NEVT = 6;
  localparam int E_SUPPLY = 0;
  localparam int E_PRESENT = 1;
  localparam int E_OV = 2;
  localparam int E_FAST = 3;
  localparam int E_T45 = 4;
  localparam int E_T55 = 5;

  bcsc_pins_s   sync1_reg;
  bcsc_pins_s   sync2_reg;
  logic         tick_d_reg;
  logic         stop_d_reg;
  logic         pres_d_reg;
  logic [NEVT-1:0] evt_raw;
  logic [NEVT-1:0] evt_reg;
  logic [4:0]   evt_cnt_reg [NEVT];
  bcsc_state_e  state_reg;
  logic         lock_reg;
  logic         ovwait_reg;
  logic         susp_reg;
  logic         bypass_reg;
  logic         holdoff_done_reg;
  logic [19:0]  timer_reg;
  logic [19:0]  holdoff_reg;
  logic [15:0]  sample_cnt_reg;
  bcsc_sample_t peak_reg;
  logic [1:0]   drop_cnt_reg;
  logic         allow_reg;
  logic         restart_reg;
  logic         tick;
  logic         stop_rise;
  logic         pres_rise;
  logic         charging;
  logic         run;
  logic         temp_ok;
  logic         qual_ok;
  logic         release_evt;
  logic         timer_done;
  logic         susp_start;
  logic         resume_fast;
  logic         dv_en;
  logic         drop;
  logic         dv_term;
  logic         set_lock;
  logic         sample_ok;
  bcsc_sample_t drop_mag;

  // Pin synchronisers
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pins_i;
      sync2_reg <= sync1_reg;
    end
  end

  // Edge detection on synchronised levels
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tick_d_reg <= 1'b0;
      stop_d_reg <= 1'b0;
      pres_d_reg <= 1'b0;
    end else begin
      tick_d_reg <= sync2_reg.osc_tick;
      stop_d_reg <= sync2_reg.stop_request_n;
      pres_d_reg <= evt_reg[E_PRESENT];
    end
  end

  assign tick      = sync2_reg.osc_tick & ~tick_d_reg;
  assign stop_rise = sync2_reg.stop_request_n & ~stop_d_reg;
  assign pres_rise = evt_reg[E_PRESENT] & ~pres_d_reg;

  // Raw events; a disabled thermistor always reads in range
  assign evt_raw[E_SUPPLY]  = ~sync2_reg.supply_lockout;
  assign evt_raw[E_PRESENT] = ~sync2_reg.above_removal;
  assign evt_raw[E_OV]      = sync2_reg.above_overvoltage;
  assign evt_raw[E_FAST]    = sync2_reg.above_fast_entry;
  assign evt_raw[E_T45]     = sync2_reg.thermistor_disabled | sync2_reg.temp_ok_45;
  assign evt_raw[E_T55]     = sync2_reg.thermistor_disabled | sync2_reg.temp_ok_55;

  // Persistence filters: a change is taken once it holds for the event delay
  for (genvar i = 0; i < NEVT; i++) begin : g_filt
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        evt_reg[i]     <= 1'b0;
        evt_cnt_reg[i] <= 5'h00;
      end else if (evt_raw[i] == evt_reg[i]) begin
        evt_cnt_reg[i] <= 5'h00;
      end else if (tick) begin
        if (evt_cnt_reg[i] == `BCSC_EVT_LAST) begin
          evt_reg[i]     <= evt_raw[i];
          evt_cnt_reg[i] <= 5'h00;
        end else begin
          evt_cnt_reg[i] <= evt_cnt_reg[i] + 5'h01;
        end
      end
    end
  end

  assign charging    = (state_reg == ST_PRECHARGE) || (state_reg == ST_FAST);
  assign run         = charging & ~susp_reg;
  assign temp_ok     = (state_reg == ST_FAST) ? evt_reg[E_T55] : evt_reg[E_T45];
  assign qual_ok     = evt_reg[E_PRESENT] & ~evt_reg[E_OV] & ~sync2_reg.die_overtemp
                     & sync2_reg.stop_request_n & allow_reg & ~lock_reg & ~ovwait_reg;
  assign release_evt = (stop_rise | pres_rise | restart_reg)
                     & ~sync2_reg.die_overtemp & ~ovwait_reg;
  assign timer_done  = (timer_reg == CHARGE_TIME_LIMIT_TICKS);
  assign susp_start  = charging & ~susp_reg & ~temp_ok;
  assign resume_fast = (state_reg == ST_FAST) & susp_reg & evt_reg[E_T45];
  assign dv_en       = bypass_reg | holdoff_done_reg;
  assign drop_mag    = sync2_reg.chemistry_select ? `BCSC_DROP_NICD : `BCSC_DROP_NIMH;
  assign drop        = (peak_reg >= adc_data_i) && ((peak_reg - adc_data_i) >= drop_mag);
  assign sample_ok   = (state_reg == ST_FAST) & ~susp_reg & adc_valid_i;
  assign dv_term     = (state_reg == ST_FAST) & (drop_cnt_reg == `BCSC_DROP_LAST)
                     & ((sample_ok & dv_en & drop) | susp_start);
  assign set_lock    = sync2_reg.die_overtemp | dv_term
                     | (charging & (evt_reg[E_OV] | timer_done));

  // Charger state machine
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= ST_SLEEP;
    end else if (sync2_reg.supply_lockout) begin
      state_reg <= ST_SLEEP;
    end else begin
      unique case (state_reg)
        ST_SLEEP: begin
          if (evt_reg[E_SUPPLY]) begin
            state_reg <= ST_SHUTDOWN;
          end
        end
        ST_SHUTDOWN: begin
          if (qual_ok) begin
            state_reg <= ST_QUALIFY;
          end
        end
        ST_QUALIFY: begin
          if (!qual_ok) begin
            state_reg <= ST_SHUTDOWN;
          end else if (evt_reg[E_T45]) begin
            state_reg <= ST_PRECHARGE;
          end
        end
        ST_PRECHARGE: begin
          if (!qual_ok || set_lock) begin
            state_reg <= ST_SHUTDOWN;
          end else if (evt_reg[E_FAST] && !susp_reg) begin
            state_reg <= ST_FAST;
          end
        end
        ST_FAST: begin
          if (dv_term) begin
            state_reg <= ST_DONE;
          end else if (!qual_ok || set_lock) begin
            state_reg <= ST_SHUTDOWN;
          end
        end
        ST_DONE: begin
          if (!lock_reg || !evt_reg[E_PRESENT] || !sync2_reg.stop_request_n) begin
            state_reg <= ST_SHUTDOWN;
          end
        end
        default: begin
          state_reg <= ST_SLEEP;
        end
      endcase
    end
  end

  // Restart lock; a power cycle through sleep clears it, a new stop wins over release
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lock_reg <= 1'b0;
    end else if (state_reg == ST_SLEEP) begin
      lock_reg <= 1'b0;
    end else if (set_lock) begin
      lock_reg <= 1'b1;
    end else if (release_evt) begin
      lock_reg <= 1'b0;
    end
  end

  // Overvoltage flag held until the cell falls below the release level
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ovwait_reg <= 1'b0;
    end else if (state_reg == ST_SLEEP) begin
      ovwait_reg <= 1'b0;
    end else if (charging && evt_reg[E_OV]) begin
      ovwait_reg <= 1'b1;
    end else if (sync2_reg.below_ov_release) begin
      ovwait_reg <= 1'b0;
    end
  end

  // Temperature suspension inside precharge and fast charge
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      susp_reg <= 1'b0;
    end else if (!charging) begin
      susp_reg <= 1'b0;
    end else if (susp_start) begin
      susp_reg <= 1'b1;
    end else if (susp_reg && evt_reg[E_T45]) begin
      susp_reg <= 1'b0;
    end
  end

  // Hold-off bypass level caught just before precharge
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bypass_reg <= 1'b0;
    end else if (state_reg == ST_QUALIFY) begin
      bypass_reg <= sync2_reg.above_holdoff_bypass;
    end
  end

  // Safety timer, paused while suspended
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      timer_reg <= 20'h0_0000;
    end else if (!charging) begin
      timer_reg <= 20'h0_0000;
    end else if (run && tick && !timer_done) begin
      timer_reg <= timer_reg + 20'h0_0001;
    end
  end

  // Stabilization hold-off in fast charge
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      holdoff_reg      <= 20'h0_0000;
      holdoff_done_reg <= 1'b0;
    end else if (state_reg != ST_FAST) begin
      holdoff_reg      <= 20'h0_0000;
      holdoff_done_reg <= 1'b0;
    end else if (resume_fast) begin
      holdoff_done_reg <= 1'b1;
    end else if (run && tick && !holdoff_done_reg) begin
      if (holdoff_reg == HOLDOFF_TICKS - 20'h0_0001) begin
        holdoff_done_reg <= 1'b1;
      end
      holdoff_reg <= holdoff_reg + 20'h0_0001;
    end
  end

  // Sampling interval and converter start
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sample_cnt_reg <= 16'h0000;
      adc_start_o    <= 1'b0;
    end else begin
      adc_start_o <= 1'b0;
      if (state_reg != ST_FAST) begin
        sample_cnt_reg <= 16'h0000;
      end else if (run && tick) begin
        if (sample_cnt_reg == SAMPLE_TICKS - 16'h0001) begin
          sample_cnt_reg <= 16'h0000;
          adc_start_o    <= 1'b1;
        end else begin
          sample_cnt_reg <= sample_cnt_reg + 16'h0001;
        end
      end
    end
  end

  // Peak tracking and consecutive drop count
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      peak_reg     <= '0;
      drop_cnt_reg <= 2'h0;
    end else if ((state_reg != ST_FAST && state_reg != ST_DONE) || resume_fast) begin
      peak_reg     <= '0;
      drop_cnt_reg <= 2'h0;
    end else if (sample_ok) begin
      if (adc_data_i > peak_reg) begin
        peak_reg <= adc_data_i;
      end
      if (dv_en && drop) begin
        if (drop_cnt_reg != `BCSC_DROP_LAST) begin
          drop_cnt_reg <= drop_cnt_reg + 2'h1;
        end
      end else begin
        drop_cnt_reg <= 2'h0;
      end
    end
  end

  // Charge path outputs
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      charge_enable_o         <= 1'b0;
      current_full_o          <= 1'b0;
      charging_indicator_n_o  <= 1'b0;
      charging_indicator_oe_o <= 1'b0;
    end else begin
      charge_enable_o         <= run;
      current_full_o          <= (state_reg == ST_FAST);
      charging_indicator_n_o  <= 1'b0;
      charging_indicator_oe_o <= charging;
    end
  end

  // Cell count decode
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cell_count_o <= 3'h1;
    end else begin
      cell_count_o <= {1'b0, sync2_reg.cell_count_select_hi, sync2_reg.cell_count_select_lo}
                    + 3'h1;
    end
  end

  // Software control; restart request is a one-cycle pulse
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      allow_reg   <= `BCSC_CTRL_RESET;
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= 1'b0;
      if (psel && penable && pready && pwrite && paddr == `BCSC_CTRL_OFS) begin
        allow_reg   <= pwdata[`BCSC_CTRL_ALLOW_BIT];
        restart_reg <= pwdata[`BCSC_CTRL_RESTART_BIT];
      end
    end
  end

  // APB answer: one access cycle, read data captured in setup
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable) begin
        unique case (paddr)
          `BCSC_CTRL_OFS: begin
            prdata[`BCSC_CTRL_ALLOW_BIT] <= allow_reg;
          end
          `BCSC_STATUS_OFS: begin
            prdata[`BCSC_ST_STATE_LSB +: 3] <= state_reg;
            prdata[`BCSC_ST_SUSP_BIT]       <= susp_reg;
            prdata[`BCSC_ST_FULL_BIT]       <= current_full_o;
            prdata[`BCSC_ST_IND_BIT]        <= charging_indicator_oe_o;
            prdata[`BCSC_ST_LOCK_BIT]       <= lock_reg;
            prdata[`BCSC_ST_OVWAIT_BIT]     <= ovwait_reg;
            prdata[`BCSC_ST_DVEN_BIT]       <= dv_en;
            prdata[`BCSC_ST_DROP_LSB +: 2]  <= drop_cnt_reg;
            prdata[`BCSC_ST_CELLS_LSB +: 3] <= cell_count_o;
          end
          `BCSC_PEAK_OFS: begin
            prdata[11:0] <= peak_reg;
          end
          `BCSC_TIMER_OFS: begin
            prdata[19:0] <= timer_reg;
          end
          default: begin
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule // bcsc_top

// File: sim/bcsc_top_properties.sv
`timescale 1ns/1ns
module bcsc_top_properties
  import bcsc_pkg::*;
(
  // Clock and reset
  input wire logic       core_clk_i,
  input wire logic       arst_n_i,
  // Observed ports
  input wire bcsc_pins_s pins_i,
  input wire logic       adc_start_o,
  input wire logic       charge_enable_o,
  input wire logic       current_full_o,
  input wire logic [2:0] cell_count_o,
  input wire logic       charging_indicator_n_o,
  input wire logic       charging_indicator_oe_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  // Held long enough to cross sync, state and output stages
  sequence s_lockout_held;
    pins_i.supply_lockout [*6];
  endsequence
  sequence s_stop_held;
    !pins_i.stop_request_n [*6];
  endsequence
  sequence s_select_steady;
    $stable({pins_i.cell_count_select_hi, pins_i.cell_count_select_lo}) [*6];
  endsequence

  AST_IND_LEVEL: assert property (charging_indicator_n_o == 1'b0)
    else $error("indicator level not low");
  AST_ENABLE_SHOWS_IND: assert property (charge_enable_o |-> charging_indicator_oe_o)
    else $error("current flows without indicator");
  AST_FULL_IN_CHARGE: assert property (current_full_o |-> charging_indicator_oe_o)
    else $error("full current outside charging");
  AST_LOCKOUT_SLEEP: assert property (s_lockout_held |-> !charging_indicator_oe_o
    && !charge_enable_o) else $error("supply low but still charging");
  AST_STOP_RELEASES: assert property (s_stop_held |-> !charge_enable_o)
    else $error("stop request ignored");
  AST_CELL_DECODE: assert property (s_select_steady |-> cell_count_o ==
    {1'b0, pins_i.cell_count_select_hi, pins_i.cell_count_select_lo} + 3'h1)
    else $error("cell count decode wrong");
  AST_ADC_PULSE: assert property (adc_start_o |=> !adc_start_o)
    else $error("converter start longer than one cycle");
  AST_ADC_FAST_ONLY: assert property (adc_start_o |-> current_full_o && charge_enable_o)
    else $error("converter started outside active fast charge");
endmodule // bcsc_top_properties

bind bcsc_top bcsc_top_properties u_bcsc_top_properties (
  .core_clk_i             (core_clk_i),
  .arst_n_i               (arst_n_i),
  .pins_i                 (pins_i),
  .adc_start_o            (adc_start_o),
  .charge_enable_o        (charge_enable_o),
  .current_full_o         (current_full_o),
  .cell_count_o           (cell_count_o),
  .charging_indicator_n_o (charging_indicator_n_o),
  .charging_indicator_oe_o(charging_indicator_oe_o)
);

// File: sim/bcsc_battery_model.sv
`timescale 1ns/1ns
module bcsc_battery_model
  import bcsc_pkg::*;
#(
  parameter int LAT = 2
) (
  // Clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         arst_n_i,
  // Converter handshake
  input  wire logic         adc_start_i,
  input  wire bcsc_sample_t level_i,
  output bcsc_sample_t      adc_data_o,
  output logic              adc_valid_o
);
  logic [LAT-1:0] pipe_reg;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pipe_reg <= '0;
      adc_valid_o <= 1'b0;
      adc_data_o <= '0;
    end else begin
      pipe_reg <= {pipe_reg[LAT-2:0], adc_start_i};
      adc_valid_o <= pipe_reg[LAT-1];
      // Cell level in 1.5 mV steps on valid, scrambled between answers
      adc_data_o <= pipe_reg[LAT-1] ? level_i : ~adc_data_o;
    end
  end
endmodule // bcsc_battery_model

// File: sim/tb_top.sv
`timescale 1ns/1ns
`include "bcsc_regs.svh"
module tb_top
  import bcsc_pkg::*;
();
  localparam logic [31:0] M_ST = 32'h0000_0007;
  logic         core_clk_i, arst_n_i, psel, penable, pwrite, pready, pslverr, err;
  logic         adc_valid, adc_start, en, full, ind_n, ind_oe;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic [2:0]   cells;
  logic [2:0]   osc_cnt = '0;
  bcsc_pins_s   pins, pins_w;
  bcsc_sample_t adc_data, level;
  int           fails, checks_done;

  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  always_ff @(posedge core_clk_i) osc_cnt <= osc_cnt + 3'h1;
  always_comb begin
    pins_w = pins;
    pins_w.osc_tick = osc_cnt[2];
  end

  bcsc_top #(.CHARGE_TIME_LIMIT_TICKS(20'h0_00c8), .HOLDOFF_TICKS(20'h0_0008), .SAMPLE_TICKS(16'h0004))
  u_bcsc_top (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .pins_i(pins_w), .adc_data_i(adc_data),
    .adc_valid_i(adc_valid), .adc_start_o(adc_start), .charge_enable_o(en),
    .current_full_o(full), .cell_count_o(cells), .charging_indicator_n_o(ind_n),
    .charging_indicator_oe_o(ind_oe), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  bcsc_battery_model u_bcsc_battery_model (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
    .adc_start_i(adc_start), .level_i(level), .adc_data_o(adc_data), .adc_valid_o(adc_valid));

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge core_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge core_clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Poll status until the masked field matches or the budget runs out
  task automatic wait_stat(input logic [31:0] mask, input logic [31:0] val, input int max);
    int n;
    n = 0;
    do begin
      apb(1'b0, `BCSC_STATUS_OFS, '0);
      n++;
    end while ((rd & mask) !== val && n < max);
  endtask

  task automatic t_reset;
    apb(1'b0, `BCSC_CTRL_OFS, '0);
    check(rd, 32'h0000_0001, "control reset value");
    apb(1'b0, 8'h10, '0);
    check({rd[30:0], err}, 32'h0000_0001, "unmapped access");
    check(32'(cells), 32'h0000_0002, "cell count");
    $display("t_reset done");
  endtask

  task automatic t_precharge;
    wait_stat(M_ST, 32'(ST_PRECHARGE), 200);
    check(rd & M_ST, 32'(ST_PRECHARGE), "precharge entry");
    check({en, full, ind_n, ind_oe}, 32'h0000_0009, "precharge outputs");
    $display("t_precharge done");
  endtask

  task automatic t_suspend;
    logic [31:0] t1;
    pins.temp_ok_45 <= 1'b0;
    wait_stat(32'h0000_0008, 32'h0000_0008, 200);
    check({en, ind_oe}, 32'h0000_0001, "suspended outputs");
    apb(1'b0, `BCSC_TIMER_OFS, '0);
    t1 = rd;
    repeat (40) @(posedge core_clk_i);
    apb(1'b0, `BCSC_TIMER_OFS, '0);
    check(rd, t1, "timer paused");
    pins.temp_ok_45 <= 1'b1;
    wait_stat(32'h0000_000f, 32'(ST_PRECHARGE), 200);
    check(rd & 32'h0000_000f, 32'(ST_PRECHARGE), "resume precharge");
    $display("t_suspend done");
  endtask

  task automatic t_fast_drop;
    level <= 12'h300;
    pins.above_fast_entry <= 1'b1;
    wait_stat(M_ST, 32'(ST_FAST), 200);
    check(rd & 32'h0000_0107, 32'(ST_FAST), "fast with hold-off");
    check(32'(full), 32'h0000_0001, "full current");
    wait_stat(32'h0000_0100, 32'h0000_0100, 200);
    check(rd & 32'h0000_0100, 32'h0000_0100, "drop detect enabled");
    apb(1'b0, `BCSC_PEAK_OFS, '0);
    check(rd, 32'h0000_0300, "peak stored");
    level <= 12'h2f6;
    repeat (300) @(posedge core_clk_i);
    apb(1'b0, `BCSC_STATUS_OFS, '0);
    check(rd & 32'h0000_0607, 32'(ST_FAST), "drop short of magnitude");
    level <= 12'h2f5;
    wait_stat(M_ST, 32'(ST_DONE), 300);
    check(rd & M_ST, 32'(ST_DONE), "drop terminates");
    check(32'(en), 32'h0000_0000, "no current when done");
    $display("t_fast_drop done");
  endtask

  task automatic stop_edge;
    pins.stop_request_n <= 1'b0;
    repeat (20) @(posedge core_clk_i);
    pins.stop_request_n <= 1'b1;
  endtask

  task automatic t_timer;
    pins.above_holdoff_bypass <= 1'b1;
    apb(1'b1, `BCSC_CTRL_OFS, 32'h0000_0003);
    wait_stat(M_ST, 32'(ST_FAST), 300);
    check(rd & 32'h0000_0107, 32'h0000_0106, "restart reaches fast");
    wait_stat(32'h0000_0047, 32'h0000_0041, 1000);
    check(rd & 32'h0000_0047, 32'h0000_0041, "time limit locks");
    check(32'(en), 32'h0000_0000, "time limit stops current");
    stop_edge;
    wait_stat(32'h0000_0040, 32'h0000_0000, 50);
    check(rd & 32'h0000_0040, 32'h0000_0000, "stop edge unlocks");
    $display("t_timer done");
  endtask

  task automatic t_fault;
    pins.above_overvoltage <= 1'b1;
    pins.below_ov_release <= 1'b0;
    wait_stat(32'h0000_00c7, 32'h0000_00c1, 200);
    check(rd & 32'h0000_00c7, 32'h0000_00c1, "overvoltage stop");
    stop_edge;
    repeat (8) @(posedge core_clk_i);
    apb(1'b0, `BCSC_STATUS_OFS, '0);
    check(rd & 32'h0000_0040, 32'h0000_0040, "no restart above release");
    pins.above_overvoltage <= 1'b0;
    pins.below_ov_release <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    stop_edge;
    wait_stat(M_ST, 32'(ST_FAST), 200);
    check(rd & M_ST, 32'(ST_FAST), "restart below release");
    pins.die_overtemp <= 1'b1;
    wait_stat(32'h0000_0047, 32'h0000_0041, 20);
    check(rd & 32'h0000_0047, 32'h0000_0041, "die heat stop");
    stop_edge;
    repeat (8) @(posedge core_clk_i);
    apb(1'b0, `BCSC_STATUS_OFS, '0);
    check(rd & 32'h0000_0040, 32'h0000_0040, "no restart while hot");
    pins.die_overtemp <= 1'b0;
    stop_edge;
    wait_stat(M_ST, 32'(ST_FAST), 50);
    check(rd & M_ST, 32'(ST_FAST), "restart once cool");
    $display("t_fault done");
  endtask

  task automatic t_nimh;
    pins.chemistry_select <= 1'b0;
    repeat (60) @(posedge core_clk_i);
    apb(1'b0, `BCSC_PEAK_OFS, '0);
    check(rd, 32'h0000_02f5, "peak after restart");
    level <= 12'h2ef;
    wait_stat(M_ST, 32'(ST_DONE), 300);
    check(rd & M_ST, 32'(ST_DONE), "metal-hydride drop");
    $display("t_nimh done");
  endtask

  task automatic t_sleep;
    pins.supply_lockout <= 1'b1;
    wait_stat(M_ST, 32'(ST_SLEEP), 50);
    check(rd & M_ST, 32'(ST_SLEEP), "lockout sleep");
    apb(1'b0, `BCSC_PEAK_OFS, '0);
    check(rd, 32'h0000_0000, "peak cleared");
    apb(1'b0, `BCSC_TIMER_OFS, '0);
    check(rd, 32'h0000_0000, "timer cleared");
    check({ind_oe, en}, 32'h0000_0000, "indicator released");
    pins.supply_lockout <= 1'b0;
    $display("t_sleep done");
  endtask

  initial begin
    fails = 0;
    checks_done = 0;
    arst_n_i = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    level = 12'h100;
    pins = '0;
    pins.below_ov_release = 1'b1;
    pins.temp_ok_45 = 1'b1;
    pins.temp_ok_55 = 1'b1;
    pins.stop_request_n = 1'b1;
    pins.chemistry_select = 1'b1;
    pins.cell_count_select_lo = 1'b1;
    repeat (20) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    t_reset;
    t_precharge;
    t_suspend;
    t_fast_drop;
    t_timer;
    t_fault;
    t_nimh;
    t_sleep;
    end_of_test;
  end

  initial begin
    repeat (60000) @(posedge core_clk_i);
    fails++;
    end_of_test;
  end
endmodule // tb_top
